// ===== src/ssp_pin_logic.sv
`timescale 1ns/1ps
module ssp_pin_logic
	import ssp_pkg::*;
#(
	parameter int WORD_BITS = ssp_pkg::WORD_W
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	input  wire ssp_pkg::ssp_bus_req_t  bus_req,
	output logic [ssp_pkg::DATA_W-1:0]  rd_data,
	input  wire logic [ssp_pkg::PIN_N-1:0] pin_in,
	output ssp_pkg::ssp_pin_drv_t       pin_drv
);
	import ssp_pkg::*;

	localparam int FW = $clog2(WORD_BITS);
	localparam logic [FW-1:0] FS_LAST  = FW'(WORD_BITS - 1);
	localparam logic [7:0]    MIN_HALF = 8'(SCLK_MIN_HALF_CYC);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [PIN_N-1:0]     func_sel, next_func_sel;
	logic [PIN_N-1:0]     dir, next_dir;
	logic [PIN_N-1:0]     gpio_out, next_gpio_out;
	ssp_ctrl_t            ctrl, next_ctrl;
	logic [WORD_BITS-1:0] tx_buf, next_tx_buf;
	logic [WORD_BITS-1:0] rx_buf, next_rx_buf;
	logic                 tx_full, next_tx_full;
	logic                 rx_full, next_rx_full;
	logic                 tx_unf, next_tx_unf;
	logic                 rx_ovf, next_rx_ovf;
	logic [DATA_W-1:0]    next_rd_data;
	ssp_pin_drv_t         next_pin_drv;

	logic [PIN_N-1:0]     pin_s;
	logic [7:0]           int_cnt, next_int_cnt;
	logic                 int_sclk, next_int_sclk;
	logic [FW-1:0]        fs_cnt, next_fs_cnt;
	logic                 sclk_prev, next_sclk_prev;
	logic                 rxclk_prev, next_rxclk_prev;

	logic [7:0]           half;
	logic                 int_tick, int_rise, int_fall;
	logic                 ext_rise, ext_fall, erx_rise, erx_fall;
	logic                 tx_rise, tx_fall, rx_rise, rx_fall;
	logic                 fs_int, tx_fs, rx_fs;
	logic                 tx_start, rx_start;
	logic [WORD_BITS-1:0] tx_word, rx_word;
	logic                 tx_busy, rx_busy, rx_done;
	logic                 tx_bit;
	logic [PIN_N-1:0]     ser_out, ser_oe;
	logic                 wr_hit_tx, rd_hit_rx;

	// ------------------------------------------------------------
	// Pin input synchroniser
	// ------------------------------------------------------------
	ssp_sync2 #(.W (PIN_N)) u_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in (pin_in),
		.sync_out (pin_s)
	);

	// ------------------------------------------------------------
	// Bit clock and frame timing
	// ------------------------------------------------------------
	always_comb begin
		// Internal clock never runs faster than an external one may
		half = (ctrl.clk_half < MIN_HALF) ? MIN_HALF : ctrl.clk_half;
		int_tick = (int_cnt >= half - 8'h01);
		int_rise = int_tick & ~int_sclk;
		int_fall = int_tick & int_sclk;
		next_int_cnt  = int_tick ? 8'h00 : int_cnt + 8'h01;
		next_int_sclk = int_tick ? ~int_sclk : int_sclk;
		ext_rise = pin_s[PIN_SCLK] & ~sclk_prev;
		ext_fall = ~pin_s[PIN_SCLK] & sclk_prev;
		erx_rise = pin_s[PIN_CTRL_A] & ~rxclk_prev;
		erx_fall = ~pin_s[PIN_CTRL_A] & rxclk_prev;
		next_sclk_prev  = pin_s[PIN_SCLK];
		next_rxclk_prev = pin_s[PIN_CTRL_A];
		tx_rise = ctrl.clk_out ? int_rise : ext_rise;
		tx_fall = ctrl.clk_out ? int_fall : ext_fall;
		if (ctrl.sync_mode) begin
			rx_rise = tx_rise;
			rx_fall = tx_fall;
		end else begin
			rx_rise = ctrl.rxclk_out ? int_rise : erx_rise;
			rx_fall = ctrl.rxclk_out ? int_fall : erx_fall;
		end
		next_fs_cnt = fs_cnt;
		if (!(ctrl.tx_en | ctrl.rx_en)) begin
			next_fs_cnt = '0;
		end else if (tx_rise) begin
			next_fs_cnt = (fs_cnt == FS_LAST) ? '0 : fs_cnt + 1'b1;
		end
		fs_int = (ctrl.tx_en | ctrl.rx_en) & (fs_cnt == '0);
		tx_fs = ctrl.fs_out ? fs_int : pin_s[PIN_FS];
		if (ctrl.sync_mode) begin
			rx_fs = tx_fs;
		end else begin
			rx_fs = ctrl.rxfs_out ? fs_int : pin_s[PIN_CTRL_B];
		end
		tx_start = tx_rise & tx_fs & ctrl.tx_en;
		rx_start = rx_rise & rx_fs & ctrl.rx_en;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			int_cnt    <= 8'h00;
			int_sclk   <= 1'b0;
			fs_cnt     <= '0;
			sclk_prev  <= 1'b0;
			rxclk_prev <= 1'b0;
		end else begin
			int_cnt    <= next_int_cnt;
			int_sclk   <= next_int_sclk;
			fs_cnt     <= next_fs_cnt;
			sclk_prev  <= next_sclk_prev;
			rxclk_prev <= next_rxclk_prev;
		end
	end

	// ------------------------------------------------------------
	// Shift words
	// ------------------------------------------------------------
	// transmit word
	ssp_shift #(.W (WORD_BITS)) u_tx (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.start    (tx_start),
		.step     (tx_rise),
		.sin      (1'b0),
		.load_val (tx_full ? tx_buf : '0),
		.data     (tx_word),
		.busy     (tx_busy),
		.done     ()
	);

	ssp_shift #(.W (WORD_BITS)) u_rx (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.start    (rx_start),
		.step     (rx_fall),
		.sin      (pin_s[PIN_RXD]),
		.load_val ('0),
		.data     (rx_word),
		.busy     (rx_busy),
		.done     (rx_done)
	);

	assign tx_bit = tx_word[WORD_BITS-1];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	always_comb begin
		next_func_sel = func_sel;
		next_dir      = dir;
		next_gpio_out = gpio_out;
		next_ctrl     = ctrl;
		next_tx_buf   = tx_buf;
		next_rx_buf   = rx_buf;
		next_tx_full  = tx_full;
		next_rx_full  = rx_full;
		next_tx_unf   = tx_unf;
		next_rx_ovf   = rx_ovf;
		wr_hit_tx = bus_req.wr & (bus_req.addr == ADDR_TX_DATA);
		rd_hit_rx = bus_req.rd & (bus_req.addr == ADDR_RX_DATA);
		if (bus_req.wr) begin
			case (bus_req.addr)
				ADDR_FUNC_SEL: next_func_sel = bus_req.wdata[PIN_N-1:0];
				ADDR_DIR:      next_dir      = bus_req.wdata[PIN_N-1:0];
				ADDR_GPIO_OUT: next_gpio_out = bus_req.wdata[PIN_N-1:0];
				ADDR_SER_CTRL: next_ctrl     = ssp_ctrl_t'(bus_req.wdata);
				ADDR_TX_DATA:  next_tx_buf   = bus_req.wdata[WORD_BITS-1:0];
				ADDR_STATUS: begin
					next_tx_unf = tx_unf & ~bus_req.wdata[ST_TX_UNDERRUN];
					next_rx_ovf = rx_ovf & ~bus_req.wdata[ST_RX_OVERRUN];
				end
				default: ;
			endcase
		end
		// Hardware sets are applied last so they win over clears
		next_tx_full = (tx_full & ~tx_start) | wr_hit_tx;
		if (tx_start & ~tx_full) begin
			next_tx_unf = 1'b1;
		end
		if (rd_hit_rx) begin
			next_rx_full = 1'b0;
		end
		if (rx_done) begin
			next_rx_buf  = rx_word;
			next_rx_full = 1'b1;
			if (rx_full & ~rd_hit_rx) begin
				next_rx_ovf = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			func_sel <= RST_FUNC_SEL;
			dir      <= RST_DIR;
			gpio_out <= RST_GPIO_OUT;
			ctrl     <= ssp_ctrl_t'(RST_SER_CTRL);
			tx_buf   <= '0;
			rx_buf   <= '0;
			tx_full  <= 1'b0;
			rx_full  <= 1'b0;
			tx_unf   <= 1'b0;
			rx_ovf   <= 1'b0;
		end else begin
			func_sel <= next_func_sel;
			dir      <= next_dir;
			gpio_out <= next_gpio_out;
			ctrl     <= next_ctrl;
			tx_buf   <= next_tx_buf;
			rx_buf   <= next_rx_buf;
			tx_full  <= next_tx_full;
			rx_full  <= next_rx_full;
			tx_unf   <= next_tx_unf;
			rx_ovf   <= next_rx_ovf;
		end
	end

	// ------------------------------------------------------------
	// Serial pin roles
	// ------------------------------------------------------------
	always_comb begin
		// Extra transmitter outputs mirror the one transmit stream
		if (ctrl.sync_mode) begin
			ser_oe[PIN_CTRL_A]  = ctrl.ctl_a_tx ? tx_busy : ctrl.flag0_dir;
			ser_out[PIN_CTRL_A] = ctrl.ctl_a_tx ? tx_bit : ctrl.flag0_val;
			ser_oe[PIN_CTRL_B]  = ctrl.ctl_b_tx ? tx_busy : ctrl.flag1_dir;
			ser_out[PIN_CTRL_B] = ctrl.ctl_b_tx ? tx_bit : ctrl.flag1_val;
		end else begin
			ser_oe[PIN_CTRL_A]  = ctrl.rxclk_out;
			ser_out[PIN_CTRL_A] = int_sclk;
			ser_oe[PIN_CTRL_B]  = ctrl.rxfs_out;
			ser_out[PIN_CTRL_B] = fs_int;
		end
		ser_oe[PIN_FS]    = ctrl.fs_out;
		ser_out[PIN_FS]   = fs_int;
		ser_oe[PIN_SCLK]  = ctrl.clk_out;
		ser_out[PIN_SCLK] = int_sclk;
		ser_oe[PIN_RXD]   = 1'b0;
		ser_out[PIN_RXD]  = 1'b0;
		ser_oe[PIN_TXD]   = tx_busy;
		ser_out[PIN_TXD]  = tx_bit;
	end

	// ------------------------------------------------------------
	// Pin multiplexer, one slice per pin
	// ------------------------------------------------------------
	for (genvar n = 0; n < PIN_N; n++) begin : g_pin
		assign next_pin_drv.oe[n]  = func_sel[n] ? ser_oe[n] : dir[n];
		assign next_pin_drv.out[n] = func_sel[n] ? ser_out[n] : gpio_out[n];
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_comb begin
		next_rd_data = '0;
		if (bus_req.rd) begin
			case (bus_req.addr)
				ADDR_FUNC_SEL:  next_rd_data = DATA_W'(func_sel);
				ADDR_DIR:       next_rd_data = DATA_W'(dir);
				ADDR_GPIO_OUT:  next_rd_data = DATA_W'(gpio_out);
				ADDR_PIN_LEVEL: next_rd_data = DATA_W'(pin_s);
				ADDR_SER_CTRL:  next_rd_data = DATA_W'(ctrl);
				ADDR_TX_DATA:   next_rd_data = DATA_W'(tx_buf);
				ADDR_RX_DATA:   next_rd_data = DATA_W'(rx_buf);
				ADDR_STATUS: begin
					next_rd_data[ST_TX_EMPTY]    = ~tx_full;
					next_rd_data[ST_RX_FULL]     = rx_full;
					next_rd_data[ST_TX_UNDERRUN] = tx_unf;
					next_rd_data[ST_RX_OVERRUN]  = rx_ovf;
					next_rd_data[ST_TX_BUSY]     = tx_busy;
					next_rd_data[ST_RX_BUSY]     = rx_busy;
				end
				default: next_rd_data = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rd_data <= '0;
			pin_drv <= '0;
		end else begin
			rd_data <= next_rd_data;
			pin_drv <= next_pin_drv;
		end
	end
endmodule // ssp_pin_logic

// ===== src/ssp_pkg.sv
package ssp_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int PIN_N  = 6;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 24;
	localparam int WORD_W = 24;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [2:0] ADDR_FUNC_SEL  = 3'h0;
	localparam logic [2:0] ADDR_DIR       = 3'h1;
	localparam logic [2:0] ADDR_GPIO_OUT  = 3'h2;
	localparam logic [2:0] ADDR_PIN_LEVEL = 3'h3;
	localparam logic [2:0] ADDR_SER_CTRL  = 3'h4;
	localparam logic [2:0] ADDR_TX_DATA   = 3'h5;
	localparam logic [2:0] ADDR_RX_DATA   = 3'h6;
	localparam logic [2:0] ADDR_STATUS    = 3'h7;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [5:0]  RST_FUNC_SEL = 6'h00;
	localparam logic [5:0]  RST_DIR      = 6'h00;
	localparam logic [5:0]  RST_GPIO_OUT = 6'h00;
	localparam logic [23:0] RST_SER_CTRL = 24'h040000;

	// ------------------------------------------------------------
	// Pin positions
	// ------------------------------------------------------------
	localparam int PIN_CTRL_A = 0;
	localparam int PIN_CTRL_B = 1;
	localparam int PIN_FS     = 2;
	localparam int PIN_SCLK   = 3;
	localparam int PIN_RXD    = 4;
	localparam int PIN_TXD    = 5;

	// ------------------------------------------------------------
	// Status bit positions
	// ------------------------------------------------------------
	localparam int ST_TX_EMPTY   = 0;
	localparam int ST_RX_FULL    = 1;
	localparam int ST_TX_UNDERRUN = 2;
	localparam int ST_RX_OVERRUN = 3;
	localparam int ST_TX_BUSY    = 4;
	localparam int ST_RX_BUSY    = 5;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ        = 200;
	localparam int SCLK_MIN_PERIOD_T  = 6;
	localparam int SCLK_MIN_HALF_CYC  = SCLK_MIN_PERIOD_T / 2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] clk_half;
		logic [2:0] rsv;
		logic       rx_en;
		logic       tx_en;
		logic       flag1_val;
		logic       flag0_val;
		logic       flag1_dir;
		logic       flag0_dir;
		logic       ctl_b_tx;
		logic       ctl_a_tx;
		logic       rxfs_out;
		logic       rxclk_out;
		logic       fs_out;
		logic       clk_out;
		logic       sync_mode;
	} ssp_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ssp_bus_req_t;

	typedef struct packed {
		logic [PIN_N-1:0] out;
		logic [PIN_N-1:0] oe;
	} ssp_pin_drv_t;

endpackage

// ===== src/ssp_sync2.sv
`timescale 1ns/1ps
module ssp_sync2 #(
	parameter int W = 6
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// ------------------------------------------------------------
	// Two-stage synchroniser, first stage read only by the second
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // ssp_sync2

// ===== src/ssp_shift.sv
`timescale 1ns/1ps
module ssp_shift #(
	parameter int W = 24
) (
	input  wire logic         sys_clk,
	input  wire logic         rstn,
	input  wire logic         start,
	input  wire logic         step,
	input  wire logic         sin,
	input  wire logic [W-1:0] load_val,
	output logic      [W-1:0] data,
	output logic              busy,
	output logic              done
);
	localparam int CW = $clog2(W);
	localparam logic [CW-1:0] LAST = CW'(W - 1);

	logic [CW-1:0] cnt;
	logic [W-1:0]  next_data;
	logic [CW-1:0] next_cnt;
	logic          next_busy;
	logic          next_done;

	// ------------------------------------------------------------
	// Word shifter: start reloads, each step while busy moves one bit MSB first
	// ------------------------------------------------------------
	always_comb begin
		next_data = data;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = step & busy & (cnt == LAST);
		// Start beats step so back-to-back words leave no gap
		if (start) begin
			next_data = load_val;
			next_cnt  = '0;
			next_busy = 1'b1;
		end else if (step & busy) begin
			next_data = {data[W-2:0], sin};
			if (cnt == LAST) begin
				next_busy = 1'b0;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			data <= '0;
			cnt  <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			data <= next_data;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end
endmodule // ssp_shift

// ===== sim/ssp_pin_logic_props.sv
`timescale 1ns/1ps
module ssp_pin_logic_props
	import ssp_pkg::*;
#(
	parameter int WORD_BITS = 24
) (
	input wire logic                       sys_clk,
	input wire logic                       rstn,
	input wire ssp_pkg::ssp_bus_req_t      bus_req,
	input wire logic [ssp_pkg::DATA_W-1:0] rd_data,
	input wire logic [ssp_pkg::PIN_N-1:0]  pin_in,
	input wire ssp_pkg::ssp_pin_drv_t      pin_drv
);
	import ssp_pkg::*;
	// ------------------------------------------------------------
	// Shadow registers
	// ------------------------------------------------------------
	logic [5:0] fsel, dir, gpo, next_fsel, next_dir, next_gpo;
	logic [5:0] gp_in, gp_drv, gp_high;
	logic [1:0] fv;
	logic       rd_fsel, fl0_on, fl1_on, rxc_on, sck_in, fs_on, rx_sel;
	ssp_ctrl_t  ctl, next_ctl;

	always_comb begin
		next_fsel = fsel;
		next_dir = dir;
		next_gpo = gpo;
		next_ctl = ctl;
		if (!rstn) begin
			next_fsel = RST_FUNC_SEL;
			next_dir = RST_DIR;
			next_gpo = RST_GPIO_OUT;
			next_ctl = ssp_ctrl_t'(RST_SER_CTRL);
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				ADDR_FUNC_SEL: next_fsel = bus_req.wdata[5:0];
				ADDR_DIR: next_dir = bus_req.wdata[5:0];
				ADDR_GPIO_OUT: next_gpo = bus_req.wdata[5:0];
				ADDR_SER_CTRL: next_ctl = ssp_ctrl_t'(bus_req.wdata);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		fsel <= next_fsel;
		dir <= next_dir;
		gpo <= next_gpo;
		ctl <= next_ctl;
	end

	assign gp_in = ~fsel;
	assign gp_drv = dir & ~fsel;
	assign gp_high = gpo & dir & ~fsel;
	assign fv = {ctl.flag1_val, ctl.flag0_val};
	assign rd_fsel = bus_req.rd && (bus_req.addr == ADDR_FUNC_SEL);
	assign fl0_on = fsel[0] & ctl.sync_mode & ~ctl.ctl_a_tx & ctl.flag0_dir;
	assign fl1_on = fsel[1] & ctl.sync_mode & ~ctl.ctl_b_tx & ctl.flag1_dir;
	assign rxc_on = fsel[0] & ~ctl.sync_mode & ctl.rxclk_out;
	assign sck_in = fsel[3] & ~ctl.clk_out;
	assign fs_on = fsel[2] & ctl.fs_out;
	assign rx_sel = fsel[4];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_reset_all_inputs: assert property (
		!$past(rstn) |-> pin_drv.oe == 6'h00 && rd_data == '0)
		else $error("pins driven right after reset");
	a_gpio_direction: assert property (
		(pin_drv.oe & $past(gp_in)) == $past(gp_drv))
		else $error("general purpose direction wrong");
	a_gpio_out_level: assert property (
		(pin_drv.out & $past(gp_drv)) == $past(gp_high))
		else $error("general purpose output level wrong");
	a_func_sel_read: assert property (
		$past(rd_fsel) |-> rd_data[5:0] == $past(fsel))
		else $error("function select readback wrong");
	a_flag0_drive: assert property (
		$past(fl0_on) |-> pin_drv.oe[0] && pin_drv.out[0] == $past(fv[0]))
		else $error("flag 0 not driven");
	a_flag1_drive: assert property (
		$past(fl1_on) |-> pin_drv.oe[1] && pin_drv.out[1] == $past(fv[1]))
		else $error("flag 1 not driven");
	a_rx_clock_out: assert property (
		$past(rxc_on) |-> pin_drv.oe[0])
		else $error("receive clock not driven");
	a_bit_clock_in: assert property (
		$past(sck_in) |-> !pin_drv.oe[3])
		else $error("external bit clock pin driven");
	a_frame_sync_out: assert property (
		$past(fs_on) |-> pin_drv.oe[2])
		else $error("frame sync output not driven");
	a_rx_data_input: assert property (
		$past(rx_sel) |-> !pin_drv.oe[4])
		else $error("receive data pin driven");
endmodule // ssp_pin_logic_props

bind ssp_pin_logic ssp_pin_logic_props #(.WORD_BITS(WORD_BITS)) u_props (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.bus_req(bus_req),
	.rd_data(rd_data),
	.pin_in(pin_in),
	.pin_drv(pin_drv)
);

// ===== sim/ssp_far_end.sv
`timescale 1ns/1ps
module ssp_far_end
	import ssp_pkg::*;
(
	input  wire ssp_pkg::ssp_pin_drv_t pin_drv,
	input  wire logic [5:0]            tb_lvl,
	input  wire logic                  go,
	input  wire logic [23:0]           rx_word,
	output logic [5:0]                 pin_in,
	output logic [23:0]                tx_word,
	output logic                       busy
);
	import ssp_pkg::*;
	logic       own, sclk, fsync, rxd;
	logic [5:0] far;
	int         i;

	// ------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------
	assign far = own ? {tb_lvl[5], rxd, sclk, fsync, tb_lvl[1:0]} : tb_lvl;
	assign pin_in = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & far);

	initial begin
		own = 1'b0;
		sclk = 1'b0;
		fsync = 1'b0;
		rxd = 1'b0;
		busy = 1'b0;
		tx_word = '0;
	end

	// ------------------------------------------------------------
	// One frame; clock stands still between frames
	// ------------------------------------------------------------
	always @(posedge go) begin
		busy = 1'b1;
		own = 1'b1;
		// Odd offset keeps the phase unrelated to the system clock
		#1.3;
		fsync = 1'b1;
		rxd = rx_word[23];
		#32;
		// 64 ns period, 32 ns halves
		for (i = 0; i < 25; i++) begin
			// Sample before the rise: the bit stands until after it
			if (i > 0) tx_word[24-i] = pin_in[5];
			sclk = 1'b1;
			// data MSB first, changed on rises
			if (i > 0 && i < 24) rxd = rx_word[23-i];
			#32;
			sclk = 1'b0;
			fsync = 1'b0;
			#32;
		end
		own = 1'b0;
		busy = 1'b0;
	end
endmodule // ssp_far_end

// ===== sim/test_ssp_pin_logic.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
	err_total++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); \
	end end
module test_ssp_pin_logic;
	import ssp_pkg::*;
	logic         sys_clk, rstn, go, far_busy;
	ssp_bus_req_t bus_req;
	ssp_pin_drv_t pin_drv;
	logic [23:0]  rd_data, tx_seen, v;
	logic [5:0]   pin_in, tb_lvl;
	int           err_total, check_count, cyc;

	ssp_pin_logic #(.WORD_BITS(24)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
		.bus_req(bus_req), .rd_data(rd_data), .pin_in(pin_in),
		.pin_drv(pin_drv));
	ssp_far_end far_u (.pin_drv(pin_drv), .tb_lvl(tb_lvl), .go(go),
		.rx_word(24'hC3A569), .pin_in(pin_in), .tx_word(tx_seen),
		.busy(far_busy));

	// ------------------------------------------------------------
	// Clock, timeout, bus tasks
	// ------------------------------------------------------------
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task wr(input logic [2:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task rd(input logic [2:0] a);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		@(negedge sys_clk);
		v = rd_data;
	endtask

	// Leaves time for the pin flop and the input synchronisers
	task settle;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd(ADDR_FUNC_SEL);
		`CHK(v[5:0], RST_FUNC_SEL)
		rd(ADDR_SER_CTRL);
		`CHK(v, RST_SER_CTRL)
		`CHK(pin_drv.oe, 6'h00)
		$display("test reset done");
	endtask

	task t_gpio;
		wr(ADDR_GPIO_OUT, 24'h00003F);
		for (int n = 0; n < 6; n++) begin
			wr(ADDR_DIR, 24'h000001 << n);
			settle();
			`CHK(pin_drv.oe, 6'h01 << n)
			rd(ADDR_PIN_LEVEL);
			`CHK(v[5:0], (6'h01 << n) | 6'h15)
		end
		wr(ADDR_DIR, 24'h000000);
		$display("test gpio done");
	endtask

	task t_modes;
		wr(ADDR_SER_CTRL, 24'h040381);
		wr(ADDR_FUNC_SEL, 24'h000003);
		settle();
		`CHK(pin_drv.out[1:0], 2'b01)
		wr(ADDR_SER_CTRL, 24'h040581);
		settle();
		`CHK(pin_drv.out[1:0], 2'b10)
		wr(ADDR_SER_CTRL, 24'h040018);
		settle();
		`CHK(pin_drv.oe[1:0], 2'b11)
		wr(ADDR_SER_CTRL, 24'h040000);
		wr(ADDR_DIR, 24'h00003F);
		settle();
		`CHK(pin_drv.oe, 6'h3C)
		wr(ADDR_DIR, 24'h000000);
		wr(ADDR_FUNC_SEL, 24'h000000);
		$display("test modes done");
	endtask

	task t_external;
		int i;
		wr(ADDR_SER_CTRL, 24'h041801);
		wr(ADDR_FUNC_SEL, 24'h00003F);
		wr(ADDR_TX_DATA, 24'h3C5A96);
		settle();
		`CHK(pin_drv.oe[4:2], 3'b000)
		@(posedge sys_clk);
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		i = 0;
		while (far_busy && i < 1000) begin
			@(posedge sys_clk);
			i++;
		end
		`CHK(tx_seen, 24'h3C5A96)
		rd(ADDR_RX_DATA);
		`CHK(v, 24'hC3A569)
		wr(ADDR_SER_CTRL, 24'h040000);
		wr(ADDR_FUNC_SEL, 24'h000000);
		$display("test external clock done");
	endtask

	task t_internal;
		int i;
		int j;
		logic [23:0] got;
		logic prev;
		wr(ADDR_TX_DATA, 24'hA5C3E1);
		wr(ADDR_FUNC_SEL, 24'h00003F);
		wr(ADDR_SER_CTRL, 24'h040807);
		settle();
		`CHK(pin_drv.oe[3:2], 2'b11)
		i = 0;
		// Pins are read between edges, never in the step that launches them
		while (pin_drv.out[2] !== 1'b1 && i < 200) begin
			@(negedge sys_clk);
			i++;
		end
		`CHK(pin_drv.out[2], 1'b1)
		// Receiver side samples on falls, so read the bit there
		for (int b = 23; b >= 0; b--) begin
			j = 0;
			prev = pin_drv.out[3];
			@(negedge sys_clk);
			while (!(prev && !pin_drv.out[3]) && j < 20) begin
				prev = pin_drv.out[3];
				@(negedge sys_clk);
				j++;
			end
			got[b] = pin_drv.out[5];
		end
		`CHK(got, 24'hA5C3E1)
		wr(ADDR_SER_CTRL, 24'h040000);
		$display("test internal clock done");
	endtask

	initial begin
		rstn = 1'b0;
		bus_req = '0;
		go = 1'b0;
		tb_lvl = 6'h15;
		err_total = 0;
		check_count = 0;
		cyc = 0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_gpio();
		t_modes();
		t_external();
		t_internal();
		print_verdict();
	end
endmodule // test_ssp_pin_logic
